// >>> sim/pfrc_plant.sv
// motor and power stage model for the restart control bench
`timescale 1ns/1ps
`default_nettype none
module pfrc_plant (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// from the control block
	input wire logic output_enable,
	input wire logic decel_stop,
	input wire logic search_active,
	input wire logic [15:0] freq_target,
	// motor feedback
	output logic [15:0] out_freq,
	output logic motor_stopped,
	output logic speed_valid,
	output logic [15:0] speed_meas
);
logic [1:0] ph;
always_ff @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		out_freq <= 16'h0;
		ph <= 2'h0;
	end else begin
		ph <= ph + 2'h1;
		// coasting loses speed slowly, driven speed slews toward target
		if (!output_enable) out_freq <= (out_freq == 16'h0) ? 16'h0 : out_freq - 16'h1;
		else if (decel_stop) out_freq <= (out_freq > 16'h10) ? out_freq - 16'h10 : 16'h0;
		else if (out_freq + 16'h10 < freq_target) out_freq <= out_freq + 16'h10;
		else if (out_freq > freq_target + 16'h10) out_freq <= out_freq - 16'h10;
		else out_freq <= freq_target;
	end
end
assign motor_stopped = out_freq == 16'h0;
assign speed_valid = search_active && ph == 2'h3;
// between readings the speed bus carries a changing pattern
assign speed_meas = speed_valid ? out_freq : {14'h0, ph} ^ 16'hA5A5;
endmodule
`default_nettype wire

// >>> sim/pfrc_top_bench.sv
// self-checking bench of the power-fail restart control block
`timescale 1ns/1ps
`default_nettype none
module pfrc_top_bench;
logic core_clk = 1'b0, rst_b = 1'b0, speed_search_select = 1'b0, undervoltage = 1'b0;
logic continuation_level = 1'b0, supply_ok = 1'b1, run_cmd = 1'b0, fault_reset = 1'b0;
logic brake_req = 1'b0, output_enable, decel_stop, steep_decel, regen_hold, search_active;
logic restart_pulse, brake_on, trip, mode_invalid, res_overheat, motor_stopped, speed_valid;
logic [2:0] power_fail_restart_mode = 3'h0;
logic [1:0] resistor_overheat_select = 2'h0;
logic [15:0] starting_frequency_setting = 16'h0064, freq_cmd = 16'h0;
logic [15:0] out_freq, speed_meas, freq_target;
int error_cnt = 0, check_count = 0, cyc = 0;
always #2 core_clk = ~core_clk;
pfrc_top u_pfrc_top (.*);
pfrc_plant u_pfrc_plant (.*);
task report_and_stop;
	$display("checks %0d mismatches %0d", check_count, error_cnt);
	if (error_cnt == 0 && check_count > 0) begin
		$display("No errors found");
	end else begin
		$display("Errors were found");
	end
	$finish;
endtask
task chk(input string n, input logic [15:0] e, input logic [15:0] g);
	check_count++;
	if (g !== e) begin
		error_cnt++;
		$display("[ERR] %s expected %h seen %h", n, e, g);
	end
endtask
task go(input logic [2:0] m, input logic s, input logic [15:0] fc);
	logic got;
	@(negedge core_clk);
	fault_reset = 1'b1;
	@(negedge core_clk);
	fault_reset = 1'b0;
	power_fail_restart_mode = m;
	speed_search_select = s;
	freq_cmd = fc;
	run_cmd = 1'b1;
	for (int i = 0; i < 200 && out_freq !== fc; i++) @(negedge core_clk);
	continuation_level = 1'b1;
	supply_ok = 1'b0;
	repeat (2) @(negedge core_clk);
	if (m == 3'h2) chk("decel", 16'h1, 16'(decel_stop));
	if (m == 3'h2) chk("steep", 16'h1, 16'(steep_decel));
	if (m == 3'h3) chk("regen", 16'h1, 16'(regen_hold));
	// corner: mode 2 left to decelerate until the motor stands
	if (m == 3'h2 && s) begin
		for (int i = 0; i < 100 && trip !== 1'b1; i++) @(negedge core_clk);
		chk("standstill_trip", 16'h1, 16'(trip));
	end
	// corner: mode 3 supply back while still running on inertia
	if (m == 3'h3 && s) begin
		continuation_level = 1'b0;
		supply_ok = 1'b1;
		@(negedge core_clk);
		chk("cont_back", fc, freq_target);
		chk("cont_regen", 16'h0, 16'(regen_hold));
		continuation_level = 1'b1;
		supply_ok = 1'b0;
		repeat (2) @(negedge core_clk);
	end
	undervoltage = 1'b1;
	repeat (2) @(negedge core_clk);
	chk("trip_fail", 16'(m inside {3'h0, 3'h2, 3'h6, 3'h7}), 16'(trip));
	chk("out_off", 16'h0, 16'(output_enable));
	chk("invalid", 16'(m > 3'h5), 16'(mode_invalid));
	undervoltage = 1'b0;
	continuation_level = 1'b0;
	supply_ok = 1'b1;
	got = 1'b0;
	for (int i = 0; i < 40 && !got; i++) begin
		@(negedge core_clk);
		got = restart_pulse === 1'b1;
	end
	chk("restart", 16'(m inside {3'h3, 3'h4, 3'h5}), 16'(got));
	chk("trip_rec", 16'(m inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7}), 16'(trip));
	if (got && m > 3'h2 && !(s && fc inside {[16'h0032:16'h04B0]}))
		chk("target", m == 3'h5 ? starting_frequency_setting : fc, freq_target);
	$display("test mode %0d search %0d freq %h done", m, s, fc);
endtask
always @(posedge core_clk) begin
	cyc++;
	if (cyc == 40000) begin
		error_cnt++;
		report_and_stop;
	end
end
initial begin
	logic [2:0] rm;
	void'($urandom(32'hDFBC749E));
	starting_frequency_setting = 16'($urandom % 600) + 16'h0001;
	repeat (3) @(negedge core_clk);
	rst_b = 1'b1;
	for (int m = 0; m < 8; m++) go(3'(m), 1'b0, 16'h0100);
	go(3'h4, 1'b1, 16'h0200);
	go(3'h4, 1'b1, 16'h0600);
	go(3'h5, 1'b1, 16'h0020);
	go(3'h4, 1'b0, 16'h0300);
	go(3'h2, 1'b1, 16'h0100);
	go(3'h3, 1'b1, 16'h0100);
	for (int j = 0; j < 12; j++) begin
		rm = 3'($urandom % 8);
		go(rm, rm > 3'h3 ? 1'($urandom % 2) : 1'b0, 16'($urandom % 960) + 16'h0080);
	end
	// long braking on each resistor choice, internal last
	for (int k = 0; k < 3; k++) begin
		@(negedge core_clk);
		resistor_overheat_select = k == 0 ? 2'h0 : k == 1 ? 2'h2 : 2'h1;
		brake_req = 1'b1;
		repeat (5000) @(negedge core_clk);
		chk("brake", 16'(resistor_overheat_select != 2'h1), 16'(brake_on));
		brake_req = 1'b0;
		$display("test brake select %0d done", resistor_overheat_select);
	end
	report_and_stop;
end
endmodule
bind pfrc_top pfrc_top_monitor u_pfrc_top_monitor (.*);
`default_nettype wire

// >>> sim/pfrc_top_monitor.sv
// checker of the power-fail restart control ports
`timescale 1ns/1ps
`default_nettype none
module pfrc_top_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// inputs
	input wire logic [2:0] power_fail_restart_mode,
	input wire logic speed_search_select,
	input wire logic [15:0] starting_frequency_setting,
	input wire logic undervoltage,
	input wire logic continuation_level,
	input wire logic motor_stopped,
	input wire logic run_cmd,
	input wire logic fault_reset,
	input wire logic speed_valid,
	input wire logic [15:0] speed_meas,
	input wire logic brake_req,
	// outputs
	input wire logic output_enable,
	input wire logic [15:0] freq_target,
	input wire logic decel_stop,
	input wire logic regen_hold,
	input wire logic search_active,
	input wire logic restart_pulse,
	input wire logic brake_on,
	input wire logic trip,
	input wire logic mode_invalid,
	input wire logic res_overheat
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_b);
// plain running state seen from the outputs
wire run_s = output_enable && !decel_stop && !regen_hold && !search_active;
sequence s_fail; run_s && run_cmd && undervoltage; endsequence
sequence s_cont; run_s && run_cmd && continuation_level && !undervoltage; endsequence
trip_now_a: assert property (s_fail ##0 power_fail_restart_mode inside {3'h0, 3'h6, 3'h7}
	|=> trip && !output_enable) else $error("no trip at undervoltage");
stop_quiet_a: assert property (s_fail ##0 power_fail_restart_mode inside {3'h1, 3'h3, 3'h4, 3'h5}
	|=> !trip && !output_enable) else $error("wrong stop at undervoltage");
trip_hold_a: assert property (trip && !(fault_reset && !undervoltage) |=> trip)
	else $error("trip dropped");
mode_check_a: assert property (mode_invalid == (power_fail_restart_mode > 3'h5))
	else $error("mode range flag wrong");
decel_go_a: assert property (s_cont ##0 power_fail_restart_mode == 3'h2 |=> decel_stop)
	else $error("no deceleration");
regen_go_a: assert property (s_cont ##0 power_fail_restart_mode == 3'h3 |=> regen_hold)
	else $error("no regeneration");
decel_trip_a: assert property (decel_stop && run_cmd && undervoltage |=> trip)
	else $error("no trip in deceleration");
pulse_one_a: assert property (restart_pulse |=> !restart_pulse)
	else $error("restart pulse too long");
start_freq_a: assert property (restart_pulse && power_fail_restart_mode == 3'h5
	&& !speed_search_select |-> freq_target == starting_frequency_setting)
	else $error("restart not at start frequency");
search_hit_a: assert property (search_active && speed_valid
	&& speed_meas inside {[16'h0032:16'h04B0]} |=> freq_target == $past(speed_meas))
	else $error("search speed not taken");
brake_gate_a: assert property (brake_on == (brake_req && !res_overheat))
	else $error("brake gating wrong");
sequence s_standstill; decel_stop && motor_stopped; endsequence
stop_trip_a: assert property (s_standstill |=> trip)
	else $error("no trip at standstill");
endmodule
`default_nettype wire

// >>> src/pfrc_defines.svh
// constants for the power-fail restart control block
`ifndef PFRC_DEFINES_SVH
`define PFRC_DEFINES_SVH

// resistor overheat select codes
`define PFRC_RES_OFF 2'h0
`define PFRC_RES_INT 2'h1
`define PFRC_RES_EXT 2'h2

// restart mode codes
`define PFRC_MODE_TRIP_NOW 3'h0
`define PFRC_MODE_TRIP_REC 3'h1
`define PFRC_MODE_DECEL 3'h2
`define PFRC_MODE_CONTINUE 3'h3
`define PFRC_MODE_RESUME 3'h4
`define PFRC_MODE_START 3'h5
`define PFRC_MODE_MAX 3'h5

// frequency in 0.1 Hz units; speed search window 5 to 120 Hz
`define PFRC_FREQ_W 16
`define PFRC_SEARCH_MIN 16'h0032
`define PFRC_SEARCH_MAX 16'h04B0

// braking resistor thermal model
`define PFRC_HEAT_W 16
`define PFRC_HEAT_INC_INT 16'h0004
`define PFRC_HEAT_INC_EXT 16'h0002
`define PFRC_HEAT_DEC 16'h0001
`define PFRC_HEAT_LIMIT 16'hF000
`define PFRC_HEAT_RELEASE 16'h8000
`define PFRC_ON_LIMIT_INT 16'h1000
`define PFRC_ON_LIMIT_EXT 16'h4000

`endif

// >>> src/pfrc_pkg.sv
// types for the power-fail restart control block
package pfrc_pkg;

	typedef enum logic [2:0] {
		PFRC_RUN,
		PFRC_CONT,
		PFRC_DECEL,
		PFRC_STOPPED,
		PFRC_TRIPPED,
		PFRC_SEARCH
	} pfrc_state_t;

endpackage

// >>> src/pfrc_res_guard.sv
// braking resistor overheat protection
`timescale 1ns/1ps
`default_nettype none
`include "pfrc_defines.svh"

module pfrc_res_guard (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// configuration
	input wire logic [1:0] resistor_overheat_select,
	// braking chopper request and grant
	input wire logic brake_req,
	output logic brake_on,
	output logic res_overheat
);

	typedef struct packed {
		logic [`PFRC_HEAT_W-1:0] heat;
		logic [`PFRC_HEAT_W-1:0] on_time;
		logic hot;
	} pfrc_res_t;

	pfrc_res_t s_q;
	pfrc_res_t s_d;
	logic enabled;
	logic [`PFRC_HEAT_W-1:0] inc;
	logic [`PFRC_HEAT_W-1:0] on_limit;

	// 0 off, 1 internal resistor, 2 external resistor
	always_comb begin
		enabled = 1'b0;
		inc = `PFRC_HEAT_INC_EXT;
		on_limit = `PFRC_ON_LIMIT_EXT;
		unique case (resistor_overheat_select)
			`PFRC_RES_INT: begin
				enabled = 1'b1;
				inc = `PFRC_HEAT_INC_INT;
				on_limit = `PFRC_ON_LIMIT_INT;
			end
			`PFRC_RES_EXT: begin
				enabled = 1'b1;
			end
			default: begin
				enabled = 1'b0;
			end
		endcase
	end

	// heat integrates frequency of use, on_time tracks continuous conduction
	always_comb begin
		s_d = s_q;
		if (brake_on) begin
			s_d.heat = (s_q.heat > `PFRC_HEAT_LIMIT) ? s_q.heat : s_q.heat + inc;
			s_d.on_time = (s_q.on_time == on_limit) ? s_q.on_time : s_q.on_time + 16'h0001;
		end else begin
			s_d.heat = (s_q.heat == 16'h0000) ? s_q.heat : s_q.heat - `PFRC_HEAT_DEC;
			s_d.on_time = 16'h0000;
		end
		if (!enabled) begin
			s_d.hot = 1'b0;
		end else if (s_q.heat >= `PFRC_HEAT_LIMIT || s_q.on_time >= on_limit) begin
			s_d.hot = 1'b1;
		end else if (s_q.heat < `PFRC_HEAT_RELEASE && !brake_req) begin
			s_d.hot = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// inhibit braking while overheated
	assign brake_on = brake_req && !(enabled && s_q.hot);
	assign res_overheat = s_q.hot;

endmodule

`default_nettype wire

// >>> src/pfrc_top.sv
// power-fail restart control: undervoltage handling and restart selection
`timescale 1ns/1ps
`default_nettype none
`include "pfrc_defines.svh"

// Operation
// - resistor protection setting: 0 off, 1 internal resistor, 2 external resistor.
// - protection tracks use frequency and continuous on time, blocks braking when hot.
// - restart mode accepts 0 to 5, each a distinct behaviour.
// - mode 0 trips and cuts output at undervoltage, no restart.
// - mode 1 stops output at undervoltage, trips at recovery, no restart.
// - mode 2 decelerates at continuation level, holding link, trips at standstill.
// - mode 2 trips at once if undervoltage arrives during deceleration.
// - mode 2 keeps trip on recovery and does not restart.
// - mode 3 regenerates at continuation level, stops untripped at undervoltage.
// - mode 3 recovery while running resumes original; after stop, held frequency.
// - mode 4 stops untripped, restarts at frequency held at failure.
// - mode 5 stops untripped, restarts from starting frequency setting.
// - speed search measures coasting speed and resumes from it.
// - speed search used only for 5 to 120 Hz, else ordinary restart.
module pfrc_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// configuration
	input wire logic [2:0] power_fail_restart_mode,
	input wire logic [1:0] resistor_overheat_select,
	input wire logic speed_search_select,
	input wire logic [`PFRC_FREQ_W-1:0] starting_frequency_setting,
	// supply monitor
	input wire logic undervoltage,
	input wire logic continuation_level,
	input wire logic supply_ok,
	// operation commands
	input wire logic run_cmd,
	input wire logic fault_reset,
	input wire logic [`PFRC_FREQ_W-1:0] freq_cmd,
	// motor feedback
	input wire logic [`PFRC_FREQ_W-1:0] out_freq,
	input wire logic motor_stopped,
	input wire logic speed_valid,
	input wire logic [`PFRC_FREQ_W-1:0] speed_meas,
	input wire logic brake_req,
	// power stage control
	output logic output_enable,
	output logic [`PFRC_FREQ_W-1:0] freq_target,
	output logic decel_stop,
	output logic steep_decel,
	output logic regen_hold,
	output logic search_active,
	output logic restart_pulse,
	output logic brake_on,
	// status
	output logic trip,
	output logic mode_invalid,
	output logic res_overheat
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		pfrc_pkg::pfrc_state_t st;
		logic [`PFRC_FREQ_W-1:0] held;
		logic [`PFRC_FREQ_W-1:0] target;
		logic [2:0] mode;
		logic trip;
		logic restart;
	} pfrc_top_t;

	pfrc_top_t s_q;
	pfrc_top_t s_d;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic in_search_window(input logic [`PFRC_FREQ_W-1:0] f);
		in_search_window = (f >= `PFRC_SEARCH_MIN) && (f <= `PFRC_SEARCH_MAX);
	endfunction

	// mode latched while running so a change does not alter an ongoing sequence
	logic mode_ok;
	assign mode_ok = (power_fail_restart_mode <= `PFRC_MODE_MAX);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.restart = 1'b0;
		unique case (s_q.st)
			pfrc_pkg::PFRC_RUN: begin
				s_d.target = freq_cmd;
				s_d.mode = mode_ok ? power_fail_restart_mode : `PFRC_MODE_TRIP_NOW;
				if (!run_cmd) begin
					s_d.st = pfrc_pkg::PFRC_RUN;
				end else if (s_d.mode == `PFRC_MODE_DECEL && (continuation_level || undervoltage)) begin
					s_d.held = out_freq;
					if (undervoltage) begin
						s_d.trip = 1'b1;
						s_d.st = pfrc_pkg::PFRC_TRIPPED;
					end else begin
						s_d.st = pfrc_pkg::PFRC_DECEL;
					end
				end else if (s_d.mode == `PFRC_MODE_CONTINUE && continuation_level && !undervoltage) begin
					s_d.held = out_freq;
					s_d.st = pfrc_pkg::PFRC_CONT;
				end else if (undervoltage) begin
					s_d.held = out_freq;
					if (s_d.mode == `PFRC_MODE_TRIP_NOW) begin
						s_d.trip = 1'b1;
						s_d.st = pfrc_pkg::PFRC_TRIPPED;
					end else begin
						s_d.st = pfrc_pkg::PFRC_STOPPED;
					end
				end
			end
			pfrc_pkg::PFRC_CONT: begin
				if (undervoltage) begin
					s_d.held = out_freq;
					s_d.st = pfrc_pkg::PFRC_STOPPED;
				end else if (supply_ok && !continuation_level) begin
					s_d.target = s_q.held;
					s_d.st = pfrc_pkg::PFRC_RUN;
				end
			end
			pfrc_pkg::PFRC_DECEL: begin
				if (undervoltage || motor_stopped) begin
					s_d.trip = 1'b1;
					s_d.st = pfrc_pkg::PFRC_TRIPPED;
				end
			end
			pfrc_pkg::PFRC_STOPPED: begin
				if (supply_ok && !undervoltage) begin
					unique case (s_q.mode)
						`PFRC_MODE_TRIP_REC: begin
							s_d.trip = 1'b1;
							s_d.st = pfrc_pkg::PFRC_TRIPPED;
						end
						`PFRC_MODE_START: begin
							s_d.target = starting_frequency_setting;
						end
						default: begin
							s_d.target = s_q.held;
						end
					endcase
					if (s_q.mode != `PFRC_MODE_TRIP_REC) begin
						s_d.st = speed_search_select ? pfrc_pkg::PFRC_SEARCH : pfrc_pkg::PFRC_RUN;
						s_d.restart = !speed_search_select;
					end
				end
			end
			pfrc_pkg::PFRC_SEARCH: begin
				if (undervoltage) begin
					s_d.st = pfrc_pkg::PFRC_STOPPED;
				end else if (speed_valid) begin
					if (in_search_window(speed_meas)) begin
						s_d.target = speed_meas;
					end
					s_d.restart = 1'b1;
					s_d.st = pfrc_pkg::PFRC_RUN;
				end
			end
			pfrc_pkg::PFRC_TRIPPED: begin
				// trip held through recovery until reset with undervoltage gone
				if (fault_reset && !undervoltage) begin
					s_d.trip = 1'b0;
					s_d.st = pfrc_pkg::PFRC_RUN;
				end
			end
			default: begin
				s_d.st = pfrc_pkg::PFRC_TRIPPED;
				s_d.trip = 1'b1;
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q.st <= pfrc_pkg::PFRC_RUN;
			s_q.held <= 16'h0000;
			s_q.target <= 16'h0000;
			s_q.mode <= 3'h0;
			s_q.trip <= 1'b0;
			s_q.restart <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// braking resistor protection
	// ----------------------------------------
	pfrc_res_guard u_res_guard (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.resistor_overheat_select(resistor_overheat_select),
		.brake_req(brake_req),
		.brake_on(brake_on),
		.res_overheat(res_overheat)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign output_enable = run_cmd && (s_q.st == pfrc_pkg::PFRC_RUN || s_q.st == pfrc_pkg::PFRC_CONT
		|| s_q.st == pfrc_pkg::PFRC_DECEL);
	assign freq_target = s_q.target;
	assign decel_stop = (s_q.st == pfrc_pkg::PFRC_DECEL);
	assign steep_decel = decel_stop;
	assign regen_hold = (s_q.st == pfrc_pkg::PFRC_CONT);
	assign search_active = (s_q.st == pfrc_pkg::PFRC_SEARCH);
	assign restart_pulse = s_q.restart;
	assign trip = s_q.trip;
	assign mode_invalid = !mode_ok;

endmodule

`default_nettype wire
